/* logic/mmwp_top.sv */
// Memory map decoder and write protection for the program and data sides
//
// Behaviour
// R1: Data side uses byte addresses with byte or word access; program side words only.
// R2: Data space 32KB on 15 bits; program space 64k words on 16 bits.
// R3: Address bit 15 on the data side marks a byte access.
// R4: Privileged level unrestricted; application writes to protected areas are blocked.
// R5: A blocked application write is captured for reporting.
// R6: Program words 0 to 56k-1 map onto the lowest 112KB of flash.
// R7: Data side sees flash as eight 16KB sections, any one selectable.
// R8: Data offsets 0 to 16KB-1 show the selected flash section.
// R9: Data-side flash reads any width; writes only whole single words.
// R10: Flash erase works on 1024-byte pages.
// R11: Top 16KB of flash only reachable through the data-side window.
// R12: Factory info page of 1024 bytes sits at data byte address 0x5000.
// R13: Info page allows byte reads, word writes, whole-page erase only.
// R14: Info page programming enabled only from the serial debug port.
// R15: SRAM appears in the top 2.5k program words.
// R16: SRAM occupies the highest 5KB of the data space.
// R17: Each 32-byte SRAM segment has its own application write-allow bit.
// R18: SRAM reads always allowed; privileged writes ignore segment bits.
// R19: Peripheral registers start at data byte address 0x4000.
// R20: Processor uses word accesses only for registers.
// R21: System-only registers ignore application writes.
// R22: 3-bit section selector, privileged writes only, picks the window section.
// R23: Blocked write latches address and sets sticky flag, raising event until cleared.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps

module mmwp_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input mmwp_pkg::mmwp_dreq_t dreq,
    output mmwp_pkg::mmwp_dsel_t dsel,
    input mmwp_pkg::mmwp_preq_t preq,
    output mmwp_pkg::mmwp_psel_t psel,
    input wire logic serial_debug_port_prog_en,
    output logic erase_strobe,
    output logic erase_info,
    output logic [mmwp_pkg::PAGE_W-1:0] erase_page,
    output logic viol_event,
    input wire logic [mmwp_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [mmwp_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import mmwp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic [SECT_W-1:0] sect_reg;
    logic [SRAM_SEGS-1:0] allow_reg;
    logic viol_flag_reg;
    logic [31:0] viol_info_reg;
    mmwp_dsel_t dsel_reg;
    mmwp_psel_t psel_reg;
    logic erase_strobe_reg;
    logic erase_info_reg;
    logic [PAGE_W-1:0] erase_page_reg;
    logic aw_hold_reg;
    logic [AXI_AW-1:0] awaddr_reg;
    logic awpriv_reg;
    logic w_hold_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    function automatic logic [3:0] reg_id(input logic [AXI_AW-1:0] a);
        logic [3:0] id;
        id = ID_NONE;
        if (a == A_CTRL) id = ID_CTRL;
        else if (a == A_STATUS) id = ID_STATUS;
        else if (a == A_VIOL) id = ID_VIOL;
        else if (a == A_CMD) id = ID_CMD;
        else if (a >= A_PROT0 && a < A_PROT0 + 8'(4 * PROT_WORDS) && a[1:0] == 2'b00)
            id = ID_PROT0 + 4'((a - A_PROT0) >> 2);
        return id;
    endfunction : reg_id

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////////
    // Data-side decode

    wire [14:0] d_off = dreq.addr[14:0];
    wire d_byte = dreq.addr[DBYTE_BIT]; // R3
    wire [14:0] d_aln = d_byte ? d_off : {d_off[14:1], 1'b0}; // R1
    wire in_flash = d_off <= D_FLASH_HI; // R8
    wire in_reg = d_off >= D_REG_LO && d_off <= D_REG_HI; // R19
    wire in_sysreg = in_reg && d_off >= D_SYSREG_LO;
    wire in_info = d_off >= D_INFO_LO && d_off <= D_INFO_HI; // R12
    wire in_sram = d_off >= D_SRAM_LO; // R16
    wire in_none = !(in_flash || in_reg || in_info || in_sram);
    wire [12:0] sram_off = 13'(d_aln - D_SRAM_LO);
    wire [7:0] seg_idx = 8'(sram_off[12:SEG_LSB]);
    wire seg_allow = allow_reg[seg_idx]; // R17
    wire app_wr = dreq.req && dreq.we && !dreq.priv;
    // Flash-window writes belong to system flash routines, so the app level is stopped too
    wire blocked = app_wr && ((in_sram && !seg_allow) || in_sysreg || in_flash); // R4 R18 R21
    // Flash cells take whole words only; byte writes are dropped, flagged only when an app write hits the flash window
    wire fmt_drop = (in_flash || in_info) && d_byte; // R9 R13
    wire info_lock = in_info && !serial_debug_port_prog_en; // R14
    wire wr_ok = dreq.we && !blocked && !fmt_drop && !info_lock && !in_none;
    wire d_go = dreq.req && (!dreq.we || wr_ok);
    wire [1:0] d_be = d_byte ? (d_off[0] ? 2'b10 : 2'b01) : 2'b11; // R1
    wire [16:0] d_flash_addr = {sect_reg, d_aln[SECT_OFF_W-1:0]}; // R7 R8 R11

    mmwp_dsel_t dsel_next;
    always_comb begin
        dsel_next = '0;
        dsel_next.flash = d_go && in_flash;
        dsel_next.regs = d_go && in_reg;
        dsel_next.info = d_go && in_info;
        dsel_next.sram = d_go && in_sram;
        dsel_next.err = dreq.req && in_none;
        dsel_next.we = dreq.req && wr_ok;
        dsel_next.be = d_be;
        dsel_next.wdata = dreq.wdata;
        if (in_flash) dsel_next.addr = d_flash_addr;
        else if (in_info) dsel_next.addr = 17'(d_aln - D_INFO_LO);
        else if (in_reg) dsel_next.addr = 17'(d_aln - D_REG_LO);
        else dsel_next.addr = 17'(sram_off);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program-side decode

    wire p_in_flash = preq.addr <= P_FLASH_HI; // R6
    wire p_in_sram = preq.addr >= P_SRAM_LO; // R15
    mmwp_psel_t psel_next;
    assign psel_next.flash = preq.req && p_in_flash;
    assign psel_next.sram = preq.req && p_in_sram;
    // The gap between flash and SRAM hides the top 16KB of flash from fetches
    assign psel_next.err = preq.req && !p_in_flash && !p_in_sram; // R11
    assign psel_next.addr = p_in_sram ? 16'(preq.addr - P_SRAM_LO) : preq.addr; // R2

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus write path

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_hold_reg || aw_take;
    wire w_have = w_hold_reg || w_take;
    wire do_wr = aw_have && w_have && !bvalid_reg;
    wire [AXI_AW-1:0] wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    wire wr_priv = aw_hold_reg ? awpriv_reg : s_axi_awprot[0];
    wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
    wire [3:0] wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    wire [3:0] wr_id = reg_id(wr_addr);
    wire wr_known = wr_id != ID_NONE;
    // Status clear and read-only words accept any level; the rest need privilege
    wire wr_open = wr_id == ID_STATUS || wr_id == ID_VIOL;
    wire wr_en = do_wr && wr_known && (wr_priv || wr_open); // R22
    wire [1:0] wr_resp = !wr_known ? RESP_DECERR : ((wr_priv || wr_open) ? RESP_OKAY : RESP_SLVERR);

    wire [31:0] ctrl_new = merge({29'h0, sect_reg}, wr_data, wr_strb);
    wire [31:0] cmd_new = merge(32'h0, wr_data, wr_strb);
    wire cmd_go = wr_en && wr_id == ID_CMD && cmd_new[CMD_GO];
    wire viol_clr = wr_en && wr_id == ID_STATUS && wr_strb[0] && wr_data[ST_VIOL];
    wire viol_flag_next = blocked || (viol_flag_reg && !viol_clr); // R23

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= '0;
            awpriv_reg <= 1'b0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            aw_hold_reg <= !do_wr && aw_have;
            w_hold_reg <= !do_wr && w_have;
            if (aw_take) awaddr_reg <= s_axi_awaddr;
            if (aw_take) awpriv_reg <= s_axi_awprot[0];
            if (w_take) wdata_reg <= s_axi_wdata;
            if (w_take) wstrb_reg <= s_axi_wstrb;
            if (do_wr) bresp_reg <= wr_resp;
            bvalid_reg <= do_wr || (bvalid_reg && !s_axi_bready);
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration and violation capture

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sect_reg <= SECT_RST;
            viol_flag_reg <= 1'b0;
            viol_info_reg <= 32'h0;
            erase_strobe_reg <= 1'b0;
            erase_info_reg <= 1'b0;
            erase_page_reg <= '0;
        end else begin
            if (wr_en && wr_id == ID_CTRL) sect_reg <= ctrl_new[SECT_W-1:0]; // R22
            viol_flag_reg <= viol_flag_next; // R5 R23
            if (blocked) viol_info_reg <= {dreq.wdata, dreq.addr}; // R5
            // Info erase always clears the whole page, and only while debug enables it
            erase_strobe_reg <= cmd_go && (!cmd_new[CMD_INFO] || serial_debug_port_prog_en); // R13
            erase_info_reg <= cmd_go && cmd_new[CMD_INFO];
            if (cmd_go) erase_page_reg <= cmd_new[PAGE_W-1:0]; // R10
        end
    end

    genvar g;
    generate
        for (g = 0; g < PROT_WORDS; g++) begin : g_prot
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    allow_reg[32*g +: 32] <= PROT_RST[32*g +: 32];
                end else if (wr_en && wr_id == ID_PROT0 + 4'(g)) begin
                    allow_reg[32*g +: 32] <= merge(allow_reg[32*g +: 32], wr_data, wr_strb); // R17
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus read path

    wire [3:0] rd_id = reg_id(s_axi_araddr);
    wire [2:0] rd_widx = 3'(rd_id - ID_PROT0);
    wire rd_prot = rd_id >= ID_PROT0 && rd_id != ID_NONE;
    wire [31:0] rd_word =
        rd_id == ID_CTRL ? {29'h0, sect_reg} :
        rd_id == ID_STATUS ? {30'h0, serial_debug_port_prog_en, viol_flag_reg} :
        rd_id == ID_VIOL ? viol_info_reg :
        rd_prot ? allow_reg[32*rd_widx +: 32] : 32'h0;
    assign s_axi_arready = !rvalid_reg;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else begin
            if (ar_take) rdata_reg <= rd_word;
            if (ar_take) rresp_reg <= rd_id == ID_NONE ? RESP_DECERR : RESP_OKAY;
            rvalid_reg <= ar_take || (rvalid_reg && !s_axi_rready);
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Registered decode outputs

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dsel_reg <= '0;
            psel_reg <= '0;
        end else begin
            dsel_reg <= dsel_next;
            psel_reg <= psel_next;
        end
    end
    assign dsel = dsel_reg;
    assign psel = psel_reg;
    assign erase_strobe = erase_strobe_reg;
    assign erase_info = erase_info_reg;
    assign erase_page = erase_page_reg;
    assign viol_event = viol_flag_reg; // R23

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_prog_flash_map: assert property ( // R6
        preq.req && preq.addr <= P_FLASH_HI |=> psel.flash && psel.addr == $past(preq.addr))
        else $error("program flash fetch mis-mapped");

    chk_prog_sram_map: assert property ( // R15
        preq.req && preq.addr >= P_SRAM_LO
        |=> psel.sram && !psel.flash && psel.addr == $past(preq.addr) - P_SRAM_LO)
        else $error("program SRAM fetch mis-mapped");

    sequence s_sect_write;
        wr_en && wr_id == ID_CTRL && wr_priv;
    endsequence
    sequence s_window_read;
        dreq.req && !dreq.we && dreq.addr[14:0] <= D_FLASH_HI;
    endsequence
    chk_window_section: assert property ( // R7
        s_window_read |=> dsel.flash && dsel.addr[16:14] == $past(sect_reg))
        else $error("flash window shows wrong section");

    chk_sect_priv: assert property ( // R22
        do_wr && wr_id == ID_CTRL && !wr_priv |=> $stable(sect_reg) ##1 s_axi_bresp == RESP_SLVERR)
        else $error("unprivileged section write took effect");

    chk_sect_write: assert property ( // R22
        s_sect_write |=> sect_reg == $past(ctrl_new[SECT_W-1:0]))
        else $error("section write did not land");

    chk_sram_block: assert property ( // R17
        blocked && in_sram |=> !dsel.we && !dsel.sram ##0 viol_event)
        else $error("protected SRAM segment written at app level");

    chk_sram_priv: assert property ( // R18
        dreq.req && dreq.we && dreq.priv && dreq.addr[14:0] >= D_SRAM_LO
        |=> dsel.sram && dsel.we)
        else $error("privileged SRAM write refused");

    chk_viol_capture: assert property ( // R5
        blocked |=> viol_flag_reg && viol_info_reg[15:0] == $past(dreq.addr))
        else $error("blocked write not captured");

    chk_viol_sticky: assert property ( // R23
        viol_flag_reg && !viol_clr && !blocked |=> viol_flag_reg [*1] ##0 viol_event)
        else $error("violation flag dropped without clear");

    chk_info_lock: assert property ( // R14
        dreq.req && dreq.we && in_info && !serial_debug_port_prog_en |=> !dsel.we)
        else $error("info page written without debug enable");

    chk_info_erase: assert property ( // R14
        cmd_go && cmd_new[CMD_INFO] && !serial_debug_port_prog_en
        |=> erase_info && !erase_strobe)
        else $error("info page erase without debug enable");

    chk_byte_flash: assert property ( // R9
        dreq.req && dreq.we && d_byte && (in_flash || in_info) |=> !dsel.we)
        else $error("byte write reached flash");

    chk_sysreg_app: assert property ( // R21
        app_wr && in_sysreg |=> !dsel.regs && !dsel.we)
        else $error("system register written at app level");

    chk_info_map: assert property ( // R12
        dreq.req && !dreq.we && in_info
        |=> dsel.info && dsel.addr == 17'($past(d_aln) - D_INFO_LO))
        else $error("info page address mis-mapped");

    chk_byte_lane: assert property ( // R3
        dreq.req && !dreq.we && dreq.addr[DBYTE_BIT] |=> dsel.be != 2'b11)
        else $error("byte access given both lanes");

endmodule : mmwp_top

/* logic/mmwp_pkg.sv */
// Address map, register layout and carrier types of the memory map and write-protect block
package mmwp_pkg;

    // Data side: 15-bit byte offset, bit 15 flags a byte access
    localparam int unsigned DADDR_W = 16;
    localparam int unsigned DBYTE_BIT = 15;
    localparam logic [14:0] D_FLASH_HI = 15'h3FFF;
    localparam logic [14:0] D_REG_LO = 15'h4000;
    localparam logic [14:0] D_REG_HI = 15'h4FFF;
    localparam logic [14:0] D_SYSREG_LO = 15'h4C00;
    localparam logic [14:0] D_INFO_LO = 15'h5000;
    localparam logic [14:0] D_INFO_HI = 15'h53FF;
    localparam logic [14:0] D_SRAM_LO = 15'h6C00;

    // Program side: 16-bit word addresses
    localparam logic [15:0] P_FLASH_HI = 16'hDFFF;
    localparam logic [15:0] P_SRAM_LO = 16'hF600;

    // Flash and SRAM organisation
    localparam int unsigned SECT_W = 3;
    localparam int unsigned SECT_OFF_W = 14;
    localparam int unsigned PAGE_W = 7;
    localparam int unsigned SEG_LSB = 5;
    localparam int unsigned SRAM_SEGS = 160;
    localparam int unsigned PROT_WORDS = 5;

    // Register bus byte offsets
    localparam int unsigned AXI_AW = 8;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_VIOL = 8'h08;
    localparam logic [7:0] A_CMD = 8'h0C;
    localparam logic [7:0] A_PROT0 = 8'h10;

    // Register identifiers
    localparam logic [3:0] ID_CTRL = 4'h0;
    localparam logic [3:0] ID_STATUS = 4'h1;
    localparam logic [3:0] ID_VIOL = 4'h2;
    localparam logic [3:0] ID_CMD = 4'h3;
    localparam logic [3:0] ID_PROT0 = 4'h4;
    localparam logic [3:0] ID_NONE = 4'hF;

    // Field positions and reset values
    localparam int unsigned ST_VIOL = 0;
    localparam int unsigned ST_DBG = 1;
    localparam int unsigned CMD_INFO = 8;
    localparam int unsigned CMD_GO = 31;
    localparam logic [2:0] SECT_RST = 3'h0;
    localparam logic [159:0] PROT_RST = {160{1'b1}};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic req;
        logic we;
        logic priv;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mmwp_dreq_t;

    typedef struct packed {
        logic flash;
        logic regs;
        logic info;
        logic sram;
        logic err;
        logic we;
        logic [1:0] be;
        logic [16:0] addr;
        logic [15:0] wdata;
    } mmwp_dsel_t;

    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } mmwp_preq_t;

    typedef struct packed {
        logic flash;
        logic sram;
        logic err;
        logic [15:0] addr;
    } mmwp_psel_t;

endpackage : mmwp_pkg

/* sim/mmwp_cpu_model.sv */
// Processor-side partner that issues data-side and program-side accesses
`timescale 1ns/10ps
module mmwp_cpu_model (
    input wire logic clk_sys,
    output mmwp_pkg::mmwp_dreq_t dreq,
    output mmwp_pkg::mmwp_preq_t preq
);
    import mmwp_pkg::*;
    initial begin
        dreq = '0;
        preq = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Idle buses carry inverted values so a stale address never looks valid
    task automatic dacc(input logic we, input logic pv, input logic bt,
                        input logic [14:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        dreq <= '{req: 1'b1, we: we, priv: pv, addr: {bt, a}, wdata: d};
        @(posedge clk_sys);
        dreq <= '{req: 1'b0, we: ~we, priv: ~pv, addr: ~{bt, a}, wdata: ~d};
        #1;
    endtask : dacc
    task automatic pacc(input logic [15:0] a);
        @(posedge clk_sys);
        preq <= '{req: 1'b1, addr: a};
        @(posedge clk_sys);
        preq <= '{req: 1'b0, addr: ~a};
        #1;
    endtask : pacc
endmodule : mmwp_cpu_model

/* sim/tb_top.sv */
// Self-checking testbench for the memory map and write-protect block
`timescale 1ns/10ps
module tb_top;
    import mmwp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic prog_en = 1'b0;
    mmwp_dreq_t dreq;
    mmwp_dsel_t dsel;
    mmwp_preq_t preq;
    mmwp_psel_t psel;
    logic erase_strobe, erase_info, viol_event;
    logic [PAGE_W-1:0] erase_page, er_page;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
    logic [2:0] aw_prot = 3'h0, ar_prot = 3'h0;
    logic [31:0] w_data = 32'h0, r_data, rd;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, er_info;
    logic [1:0] b_resp, r_resp, rs;
    int num_errors = 0, cmp_count = 0, er_cnt = 0, e0;
    always #2.5 clk_sys = ~clk_sys;
    mmwp_cpu_model cpu (.clk_sys(clk_sys), .dreq(dreq), .preq(preq));
    mmwp_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .dreq(dreq), .dsel(dsel), .preq(preq),
        .psel(psel), .serial_debug_port_prog_en(prog_en), .erase_strobe(erase_strobe),
        .erase_info(erase_info), .erase_page(erase_page), .viol_event(viol_event),
        .s_axi_awaddr(aw_addr), .s_axi_awprot(aw_prot), .s_axi_awvalid(aw_valid),
        .s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
        .s_axi_arprot(ar_prot), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
        .s_axi_rready(r_ready));
    // Erase strobes are single pulses, so a monitor counts them
    always @(posedge clk_sys) begin
        if (erase_strobe === 1'b1) begin
            er_cnt <= er_cnt + 1;
            er_page <= erase_page;
            er_info <= erase_info;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
        @(posedge clk_sys);
        aw_addr <= a;
        aw_prot <= p;
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (aw_valid && aw_ready) aw_valid <= 1'b0;
            if (w_valid && w_ready) w_valid <= 1'b0;
            if (b_valid && b_ready) begin
                rs = b_resp;
                b_ready <= 1'b0;
                break;
            end
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk_sys);
        ar_addr <= a;
        ar_prot <= 3'h1;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (ar_valid && ar_ready) ar_valid <= 1'b0;
            if (r_valid && r_ready) begin
                rd = r_data;
                rs = r_resp;
                r_ready <= 1'b0;
                break;
            end
        end
    endtask : axi_rd
    // Flags: flash regs info sram err we; an address of all ones skips the address check
    task automatic dx(input logic we, pv, bt, input logic [14:0] a, input logic [15:0] d,
                      input logic [5:0] ef, input logic [16:0] ea, input string m);
        cpu.dacc(we, pv, bt, a, d);
        chk(32'({dsel.flash, dsel.regs, dsel.info, dsel.sram, dsel.err, dsel.we}), 32'(ef), m);
        if (ea != 17'h1FFFF) chk(32'(dsel.addr), 32'(ea), m);
    endtask : dx
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        axi_rd(A_CTRL);
        chk(rd, 32'h0, "ctrl rst");
        axi_rd(8'h20);
        chk(rd, 32'hFFFFFFFF, "prot rst");
        axi_rd(8'h40);
        chk(32'(rs), 32'(RESP_DECERR), "unmapped");
        axi_wr(8'h40, 32'h0, 3'h1);
        chk(32'(rs), 32'(RESP_DECERR), "unmapped wr");
    endtask : t_reset
    task automatic t_window();
        for (int s = 0; s < 8; s++) begin
            axi_wr(A_CTRL, 32'(s), 3'h1);
            dx(1'b0, 1'b0, 1'b0, 15'h0010, 16'h0, 6'h20, {3'(s), 14'h0010}, "section");
        end
        axi_wr(A_CTRL, 32'h2, 3'h0);
        chk(32'(rs), 32'(RESP_SLVERR), "ctrl app");
        dx(1'b0, 1'b0, 1'b1, 15'h3FFF, 16'h0, 6'h20, 17'h1FFFF, "byte rd");
        chk(32'(dsel.be), 32'h2, "be odd");
        dx(1'b1, 1'b1, 1'b0, 15'h0020, 16'h1234, 6'h21, {3'h7, 14'h0020}, "fl wr");
        chk(32'(dsel.wdata), 32'h1234, "wdata");
        dx(1'b1, 1'b1, 1'b1, 15'h0020, 16'h1234, 6'h00, 17'h1FFFF, "fl byte wr");
    endtask : t_window
    task automatic t_viol();
        dx(1'b1, 1'b0, 1'b0, 15'h0100, 16'hBEEF, 6'h00, 17'h1FFFF, "app fl");
        chk(32'(viol_event), 32'h1, "viol set");
        axi_rd(A_VIOL);
        chk(rd, 32'hBEEF0100, "viol cap");
        axi_wr(A_STATUS, 32'h1, 3'h0);
        chk(32'(viol_event), 32'h0, "viol clr");
    endtask : t_viol
    task automatic t_sram();
        axi_wr(A_PROT0, 32'hFFFFFFFE, 3'h1);
        axi_wr(8'h20, 32'h7FFFFFFF, 3'h1);
        dx(1'b1, 1'b0, 1'b0, 15'h6C00, 16'h1111, 6'h00, 17'h1FFFF, "seg0 app");
        dx(1'b1, 1'b0, 1'b0, 15'h7FFE, 16'h1111, 6'h00, 17'h1FFFF, "seg159 app");
        dx(1'b1, 1'b1, 1'b0, 15'h6C00, 16'h2222, 6'h05, 17'h0, "seg0 priv");
        dx(1'b0, 1'b0, 1'b0, 15'h6C00, 16'h0, 6'h04, 17'h0, "seg0 rd");
        dx(1'b1, 1'b0, 1'b0, 15'h6C20, 16'h3333, 6'h05, 17'h20, "seg1 app");
        axi_wr(A_STATUS, 32'h1, 3'h1);
    endtask : t_sram
    task automatic t_info();
        dx(1'b1, 1'b1, 1'b0, 15'h5000, 16'hA5A5, 6'h00, 17'h1FFFF, "info locked");
        @(posedge clk_sys) prog_en <= 1'b1;
        dx(1'b1, 1'b1, 1'b0, 15'h5002, 16'hA5A5, 6'h09, 17'h2, "info wr");
        dx(1'b1, 1'b1, 1'b1, 15'h5003, 16'hA5A5, 6'h00, 17'h1FFFF, "info byte");
        dx(1'b0, 1'b0, 1'b1, 15'h53FF, 16'h0, 6'h08, 17'h3FF, "info rd");
        axi_rd(A_STATUS);
        chk(rd, 32'h2, "dbg status");
        prog_en <= 1'b0;
    endtask : t_info
    task automatic t_regs();
        dx(1'b1, 1'b0, 1'b0, 15'h4000, 16'h5, 6'h11, 17'h0, "reg app");
        dx(1'b1, 1'b0, 1'b0, 15'h4C00, 16'h5, 6'h00, 17'h1FFFF, "sysreg app");
        chk(32'(viol_event), 32'h1, "sys viol");
        dx(1'b1, 1'b1, 1'b0, 15'h4C00, 16'h5, 6'h11, 17'hC00, "sysreg priv");
        dx(1'b0, 1'b0, 1'b0, 15'h5400, 16'h0, 6'h02, 17'h1FFFF, "gap");
        axi_wr(A_STATUS, 32'h1, 3'h1);
    endtask : t_regs
    task automatic t_prog();
        logic [15:0] pa [5] = '{16'h0000, 16'hDFFF, 16'hE000, 16'hF600, 16'hFFFF};
        logic [2:0] pf [5] = '{3'h4, 3'h4, 3'h1, 3'h2, 3'h2};
        logic [15:0] px [5] = '{16'h0000, 16'hDFFF, 16'h0, 16'h0000, 16'h09FF};
        for (int i = 0; i < 5; i++) begin
            cpu.pacc(pa[i]);
            chk(32'({psel.flash, psel.sram, psel.err}), 32'(pf[i]), "prog map");
            if (i != 2) chk(32'(psel.addr), 32'(px[i]), "prog addr");
        end
    endtask : t_prog
    task automatic t_erase();
        e0 = er_cnt;
        axi_wr(A_CMD, 32'h80000003, 3'h0);
        chk(32'(rs), 32'(RESP_SLVERR), "cmd app");
        axi_wr(A_CMD, 32'h80000003, 3'h1);
        repeat (2) @(posedge clk_sys);
        chk(32'({er_page, er_info}), 32'h6, "page erase");
        axi_wr(A_CMD, 32'h80000105, 3'h1);
        repeat (2) @(posedge clk_sys);
        chk(32'(er_cnt - e0), 32'h1, "info locked");
        prog_en <= 1'b1;
        axi_wr(A_CMD, 32'h80000105, 3'h1);
        repeat (2) @(posedge clk_sys);
        chk(32'({er_cnt - e0, er_info}), 32'h5, "info erase");
        axi_rd(A_CMD);
        chk(rd, 32'h0, "cmd rd");
        prog_en <= 1'b0;
    endtask : t_erase
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_window();
        t_viol();
        t_sram();
        t_info();
        t_regs();
        t_prog();
        t_erase();
        tally_and_finish();
    end
endmodule : tb_top
